// ---- design/tmc_pkg.sv ----
package tmc_pkg;

  localparam int unsigned CNT_W   = 12;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned NIB_W   = 4;

  localparam logic [11:0] CNT_MAX = 12'hFFF;
  localparam logic [11:0] CNT_RST = 12'h000;
  localparam logic [11:0] CAP_RST = 12'h000;

  // Mode field encodings
  localparam logic [1:0] MODE_TIMER   = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_RELOAD  = 2'h2;
  localparam logic [1:0] MODE_COMPARE = 2'h3;

  // Prescaler select encodings
  localparam logic [1:0] DIV_4   = 2'h0;
  localparam logic [1:0] DIV_16  = 2'h1;
  localparam logic [1:0] DIV_32  = 2'h2;
  localparam logic [1:0] DIV_128 = 2'h3;

  // Terminal values of the free prescale counter for each divisor
  localparam int unsigned PRE_W       = 7;
  localparam logic [6:0]  PRE_END_4   = 7'h03;
  localparam logic [6:0]  PRE_END_16  = 7'h0F;
  localparam logic [6:0]  PRE_END_32  = 7'h1F;
  localparam logic [6:0]  PRE_END_128 = 7'h7F;
  localparam logic [6:0]  PRE_RST     = 7'h00;

  // Machine cycle of four states; the pin is sampled in the last one
  localparam int unsigned MC_W    = 2;
  localparam logic [1:0]  MC_RST  = 2'h0;
  localparam logic [1:0]  MC_C4   = 2'h3;

  // Field positions within the shared high-nibble register
  localparam int unsigned SH_CNT_LSB = 0;
  localparam int unsigned SH_CAP_LSB = 4;

endpackage

// ---- design/tmc_prescaler.sv ----
`timescale 1ns/100ps
module tmc_prescaler
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic [1:0] prescaler_select,
  output logic            pre_tick,
  output logic            c4_tick
);

  logic [6:0] pre_q;
  logic [1:0] mc_q;
  logic [6:0] pre_end;

  always_comb
  begin
    unique case (prescaler_select)
      tmc_pkg::DIV_4:   pre_end = tmc_pkg::PRE_END_4;
      tmc_pkg::DIV_16:  pre_end = tmc_pkg::PRE_END_16;
      tmc_pkg::DIV_32:  pre_end = tmc_pkg::PRE_END_32;
      default:          pre_end = tmc_pkg::PRE_END_128;
    endcase
  end

  // Free-running; a divisor change takes effect at the next wrap of the
  // masked bits, so a select change may shorten one period
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pre_q <= tmc_pkg::PRE_RST;
    else if (clk_en)
      pre_q <= pre_q + 7'h01;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      mc_q <= tmc_pkg::MC_RST;
    else if (clk_en)
      mc_q <= mc_q + 2'h1;
  end

  assign pre_tick = clk_en && ((pre_q & pre_end) == pre_end); // [R4]
  assign c4_tick  = clk_en && (mc_q == tmc_pkg::MC_C4);        // [R7]

endmodule // tmc_prescaler

// ---- design/tmc_timer.sv ----
// Contract
// [R1] Twelve-bit up counter: low byte plus nibble
// [R2] Two-bit mode field picks one of four modes
// [R3] Timer mode counts 000h to FFFh, wraps
// [R4] Prescaler divides clock by 4, 16, 32, 128
// [R5] Count writes accepted only while stopped
// [R6] Source select: prescaled clock or pin edges
// [R7] Pin sampled at C4; high-then-low counts
// [R8] Toggle enable inverts pin on overflow/match
// [R9] Capture mode copies counter on trigger edge
// [R10] Capture sets event flag; software clears
// [R11] Auto-reset clears counter after capture
// [R12] Capture source: pin or ADC compare result
// [R13] Compare mode: equality sets event flag (here not for compare value 000h)
// [R14] Compare: auto-reset clears counter after match
// [R15] Reload mode counts from reload value up
// [R16] Reload overflow loads value, sets overflow flag
// [R17] Runs only when enabled; overflow sets flag (here not in compare mode)
`timescale 1ns/100ps
module tmc_timer
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic [1:0]  mode,
  input  wire logic [1:0]  prescaler_select,
  input  wire logic        run_control,
  input  wire logic        count_source_select,
  input  wire logic        pin_toggle_enable,
  input  wire logic        auto_reset_on_event,
  input  wire logic        capture_source_select,
  input  wire logic        timer_irq_enable,
  input  wire logic        count_low_wr,
  input  wire logic [7:0]  count_low_wdata,
  input  wire logic        capture_low_wr,
  input  wire logic [7:0]  capture_low_wdata,
  input  wire logic        shared_high_wr,
  input  wire logic [7:0]  shared_high_wdata,
  input  wire logic        overflow_flag_clr,
  input  wire logic        external_event_flag_clr,
  input  wire logic        adc_compare_result,
  input  wire logic        trigger_pin_in,
  input  wire logic        timer_pin_in,
  output logic             timer_pin_out,
  output logic             timer_pin_oe,
  output logic [7:0]       count_low_byte,
  output logic [7:0]       capture_low_byte,
  output logic [7:0]       shared_high_nibbles_reg,
  output logic             overflow_flag,
  output logic             external_event_flag,
  output logic             timer_irq
);

  logic        pre_tick;
  logic        c4_tick;

  logic [11:0] cnt_q;
  logic [11:0] cap_q;
  logic        ovf_flag_q;
  logic        ext_flag_q;
  logic        pin_q;
  logic        match_q;

  logic [1:0]  tpin_sync_q;
  logic [1:0]  trig_sync_q;
  logic        tpin_samp_q;
  logic        tpin_prev_q;
  logic        trig_prev_q;
  logic        adc_prev_q;

  logic        is_timer;
  logic        is_capture;
  logic        is_reload;
  logic        is_compare;
  logic        pin_fall;
  logic        count_tick;
  logic        at_max;
  logic        overflow;
  logic [11:0] cnt_inc;
  logic        match;
  logic        trig_edge;
  logic        adc_edge;
  logic        capture;
  logic        cmp_clear;

  tmc_prescaler u_prescaler
  (
    .clk              (clk),
    .arst_n           (arst_n),
    .clk_en           (clk_en),
    .prescaler_select (prescaler_select),
    .pre_tick         (pre_tick),
    .c4_tick          (c4_tick)
  );

  assign is_timer   = (mode == tmc_pkg::MODE_TIMER);   // [R2]
  assign is_capture = (mode == tmc_pkg::MODE_CAPTURE); // [R2]
  assign is_reload  = (mode == tmc_pkg::MODE_RELOAD);  // [R2]
  assign is_compare = (mode == tmc_pkg::MODE_COMPARE); // [R2]

  // Both pins come from outside the clock domain
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tpin_sync_q <= 2'h0;
    else if (clk_en)
      tpin_sync_q <= {tpin_sync_q[0], timer_pin_in};
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      trig_sync_q <= 2'h0;
    else if (clk_en)
      trig_sync_q <= {trig_sync_q[0], trigger_pin_in};
  end

  // One sample per machine cycle; pulses shorter than a machine cycle
  // may be missed, which is the documented limit of this input
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tpin_samp_q <= 1'b0;
      tpin_prev_q <= 1'b0;
    end
    else if (c4_tick)
    begin
      tpin_samp_q <= tpin_sync_q[1]; // [R7]
      tpin_prev_q <= tpin_samp_q;    // [R7]
    end
  end

  // Fall seen once, in the cycle right after the sample updates
  logic c4_dly_q;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      c4_dly_q <= 1'b0;
    else if (clk_en)
      c4_dly_q <= c4_tick;
  end

  assign pin_fall = c4_dly_q && clk_en && tpin_prev_q && !tpin_samp_q; // [R7]

  // Edge detectors arm only once the synchronisers hold real levels;
  // a source sitting high through reset would otherwise fake a capture
  logic [2:0] arm_q;
  logic       armed;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      arm_q <= 3'h0;
    else if (clk_en)
      arm_q <= {arm_q[1:0], 1'b1};
  end

  assign armed = arm_q[2];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      trig_prev_q <= 1'b0;
    else if (clk_en)
      trig_prev_q <= trig_sync_q[1];
  end

  // The comparator result is already on this clock, so it is not
  // synchronised; one register is enough to see its edges
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      adc_prev_q <= 1'b0;
    else if (clk_en)
      adc_prev_q <= adc_compare_result;
  end

  // Either edge of the selected source triggers a capture
  assign trig_edge = trig_sync_q[1] != trig_prev_q;
  assign adc_edge  = adc_compare_result != adc_prev_q;
  assign capture   = clk_en && armed &&
                     is_capture &&
                     (capture_source_select ? adc_edge : trig_edge); // [R9] [R12]

  // Counting
  assign count_tick = clk_en && run_control &&
                      (count_source_select ? pin_fall : pre_tick); // [R6] [R17]
  assign at_max     = (cnt_q == tmc_pkg::CNT_MAX);
  assign overflow   = count_tick && at_max;                       // [R3]
  assign cnt_inc    = cnt_q + 12'h001;                            // [R1]
  assign match      = count_tick && is_compare && !at_max &&
                      (cnt_inc == cap_q);                          // [R13]
  assign cmp_clear  = clk_en && match_q && is_compare &&
                      auto_reset_on_event;                         // [R14]

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      match_q <= 1'b0;
    else if (clk_en)
      match_q <= match;
  end

  // Counter: low byte and the low nibble of the shared register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= tmc_pkg::CNT_RST;
    else if (clk_en)
    begin
      if (!run_control && (count_low_wr || shared_high_wr))
      begin
        if (count_low_wr)
          cnt_q[7:0] <= count_low_wdata;                           // [R5]
        if (shared_high_wr)
          cnt_q[11:8] <= shared_high_wdata[tmc_pkg::SH_CNT_LSB +: 4]; // [R5]
      end
      else if (capture && auto_reset_on_event)
        cnt_q <= tmc_pkg::CNT_RST;                                 // [R11]
      else if (cmp_clear)
        cnt_q <= tmc_pkg::CNT_RST;                                 // [R14]
      else if (overflow)
      begin
        if (is_reload)
          cnt_q <= cap_q;                                          // [R15] [R16]
        else
          cnt_q <= tmc_pkg::CNT_RST;                               // [R3] [R14]
      end
      else if (count_tick)
        cnt_q <= cnt_inc;                                          // [R1]
    end
  end

  // Capture/reload/compare register; a capture beats a software write
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cap_q <= tmc_pkg::CAP_RST;
    else if (clk_en)
    begin
      if (capture)
        cap_q <= cnt_q;                                            // [R9]
      else
      begin
        if (capture_low_wr)
          cap_q[7:0] <= capture_low_wdata;
        if (shared_high_wr)
          cap_q[11:8] <= shared_high_wdata[tmc_pkg::SH_CAP_LSB +: 4];
      end
    end
  end

  // Sticky flags: a hardware set wins over a software clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ovf_flag_q <= 1'b0;
    else if (clk_en)
    begin
      if (overflow && !is_compare)
        ovf_flag_q <= 1'b1;                                        // [R16] [R17]
      else if (overflow_flag_clr)
        ovf_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ext_flag_q <= 1'b0;
    else if (clk_en)
    begin
      if (capture || match)
        ext_flag_q <= 1'b1;                                        // [R10] [R13]
      else if (external_event_flag_clr)
        ext_flag_q <= 1'b0;                                        // [R10]
    end
  end

  // Pin toggle on overflow in any mode or on a compare match
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pin_q <= 1'b0;
    else if (clk_en && pin_toggle_enable && (overflow || match))
      pin_q <= !pin_q;                                             // [R8]
  end

  assign timer_pin_out = pin_q;
  assign timer_pin_oe  = pin_toggle_enable;                        // [R8]

  assign count_low_byte          = cnt_q[7:0];
  assign capture_low_byte        = cap_q[7:0];
  assign shared_high_nibbles_reg = {cap_q[11:8], cnt_q[11:8]};     // [R1]
  assign overflow_flag           = ovf_flag_q;
  assign external_event_flag     = ext_flag_q;
  assign timer_irq = timer_irq_enable && (ovf_flag_q || ext_flag_q); // [R10]

  // is_timer documents the default path; nothing else needs it
  logic unused_mode;
  assign unused_mode = is_timer;

endmodule // tmc_timer

// ---- test/tmc_pin_model.sv ----
`timescale 1ns/100ps
module tmc_pin_model
(
  input  wire logic clk,
  output logic      trigger_pin_in,
  output logic      timer_pin_in,
  output logic      adc_compare_result
);
  initial
  begin
    trigger_pin_in = 1'b0;
    timer_pin_in = 1'b1;
    adc_compare_result = 1'b0;
  end
  // Each level held two machine cycles so the C4 sample sees both
  task automatic pin_fall();
    repeat (8) @(posedge clk);
    #2 timer_pin_in = 1'b0;
    repeat (8) @(posedge clk);
    #2 timer_pin_in = 1'b1;
  endtask
  task automatic trig_edge();
    @(posedge clk);
    #2 trigger_pin_in = !trigger_pin_in;
  endtask
  task automatic adc_edge();
    @(posedge clk);
    #2 adc_compare_result = !adc_compare_result;
  endtask
endmodule // tmc_pin_model

// ---- test/tmc_timer_asserts.sv ----
`timescale 1ns/100ps
module tmc_timer_asserts
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic [1:0] mode,
  input wire logic       run_control,
  input wire logic       pin_toggle_enable,
  input wire logic       auto_reset_on_event,
  input wire logic       capture_source_select,
  input wire logic       timer_irq_enable,
  input wire logic       count_low_wr,
  input wire logic       capture_low_wr,
  input wire logic       shared_high_wr,
  input wire logic       adc_compare_result,
  input wire logic       timer_pin_out,
  input wire logic       timer_pin_oe,
  input wire logic [7:0] count_low_byte,
  input wire logic [7:0] capture_low_byte,
  input wire logic [7:0] shared_high_nibbles_reg,
  input wire logic       overflow_flag,
  input wire logic       external_event_flag,
  input wire logic       timer_irq
);
  logic [11:0] cnt;
  logic [11:0] cap;
  logic        wr;
  assign cnt = {shared_high_nibbles_reg[3:0], count_low_byte};
  assign cap = {shared_high_nibbles_reg[7:4], capture_low_byte};
  assign wr = count_low_wr | capture_low_wr | shared_high_wr;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_OE: assert property (timer_pin_oe == pin_toggle_enable)
    else $error("pin enable differs");
  AST_IRQ: assert property (timer_irq == (timer_irq_enable &
    (overflow_flag | external_event_flag))) else $error("irq differs");
  AST_STOP: assert property (mode == tmc_pkg::MODE_TIMER &&
    !run_control && !wr |=> $stable(cnt)) else $error("moved stopped");
  AST_STEP: assert property (mode == tmc_pkg::MODE_TIMER && !wr |=>
    cnt == $past(cnt) || cnt == $past(cnt) + 12'h001)
    else $error("bad step");
  AST_OVF: assert property (mode == tmc_pkg::MODE_TIMER &&
    cnt == 12'hFFF && !wr ##1 cnt == 12'h000 |-> overflow_flag &&
    timer_pin_out == ($past(timer_pin_out) ^ $past(pin_toggle_enable)))
    else $error("bad overflow");
  AST_RELOAD: assert property (mode == tmc_pkg::MODE_RELOAD &&
    cnt == 12'hFFF && !wr ##1 cnt != 12'hFFF |->
    cnt == $past(cap) && overflow_flag) else $error("bad reload");
  AST_CAPT: assert property (mode == tmc_pkg::MODE_CAPTURE &&
    capture_source_select && $changed(adc_compare_result) && !wr |->
    ##[1:2] external_event_flag) else $error("no capture");
  AST_CMP: assert property (mode == tmc_pkg::MODE_COMPARE &&
    !wr && cnt != cap ##1 cnt == cap && cap != 12'h000 |->
    external_event_flag) else $error("no match flag");
  AST_CMPRST: assert property (mode == tmc_pkg::MODE_COMPARE &&
    auto_reset_on_event && !wr && cnt != cap ##1
    cnt == cap && cap != 12'h000 |=> cnt == 12'h000)
    else $error("no clear");
  cover property ($rose(overflow_flag));
  cover property ($rose(external_event_flag));
  cover property (mode == tmc_pkg::MODE_RELOAD && $rose(overflow_flag));
endmodule // tmc_timer_asserts
bind tmc_timer tmc_timer_asserts chk_u (.*);

// ---- test/twelve_bit_capture_compare_timer_tb_top.sv ----
`timescale 1ns/100ps
module twelve_bit_capture_compare_timer_tb_top;
  logic clk, arst_n, clk_en, run_control, count_source_select;
  logic pin_toggle_enable, auto_reset_on_event, capture_source_select;
  logic timer_irq_enable, count_low_wr, capture_low_wr, shared_high_wr;
  logic overflow_flag_clr, external_event_flag_clr, timer_irq;
  logic adc_compare_result, trigger_pin_in, timer_pin_in;
  logic timer_pin_out, timer_pin_oe, overflow_flag, external_event_flag;
  logic [1:0]  mode, prescaler_select;
  logic [7:0]  count_low_wdata, capture_low_wdata, shared_high_wdata;
  logic [7:0]  count_low_byte, capture_low_byte, shared_high_nibbles_reg;
  logic [13:0] exp_q[$];
  logic [11:0] r;
  int          err_total, checks_done, n;
  int          per[4] = '{4, 16, 32, 128};
  tmc_timer dut_u (.*);
  tmc_pin_model pin_u (.*);
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [11:0] obs(input logic [1:0] s);
    case (s)
      2'h0: return {shared_high_nibbles_reg[3:0], count_low_byte};
      2'h1: return {shared_high_nibbles_reg[7:4], capture_low_byte};
      default: return {8'h00, overflow_flag, external_event_flag,
                       timer_irq, timer_pin_out};
    endcase
  endfunction
  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    checks_done++;
    if (seen !== want)
    begin
      err_total++;
      $display("wrong value at %0t: %h, want %h", $time, seen, want);
    end
  endtask
  task automatic note(input logic [1:0] s, input logic [11:0] v);
    exp_q.push_back({s, v});
  endtask
  initial
  forever
  begin
    logic [13:0] e;
    wait (exp_q.size() != 0);
    e = exp_q.pop_front();
    check(obs(e[13:12]), e[11:0]);
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic step();
    r = obs(2'h0);
    n = 0;
    while (obs(2'h0) === r && n < 300)
    begin
      cyc(1);
      n++;
    end
  endtask
  task automatic wait_for(input logic [1:0] s, input logic [11:0] v);
    n = 0;
    while (obs(s) !== v && n < 3000)
    begin
      cyc(1);
      n++;
    end
  endtask
  // Counter writes only while stopped
  task automatic load(input logic [11:0] c, input logic [11:0] p);
    {count_low_wr, capture_low_wr, shared_high_wr} = 3'h7;
    {count_low_wdata, capture_low_wdata} = {c[7:0], p[7:0]};
    shared_high_wdata = {p[11:8], c[11:8]};
    cyc(1);
    {count_low_wr, capture_low_wr, shared_high_wr} = 3'h0;
  endtask
  task automatic clr_flags(input logic [1:0] f);
    {overflow_flag_clr, external_event_flag_clr} = f;
    cyc(1);
    {overflow_flag_clr, external_event_flag_clr} = 2'h0;
  endtask
  task automatic done(input int k);
    $display("test %0d finished", k);
  endtask
  task automatic end_of_test();
    #1;
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    cyc(20000);
    err_total++;
    end_of_test();
  end
  initial
  begin
    {clk_en, arst_n, mode, prescaler_select} = 6'h20;
    {run_control, count_source_select, pin_toggle_enable} = 3'h0;
    {auto_reset_on_event, capture_source_select, timer_irq_enable} = 3'h0;
    {count_low_wr, capture_low_wr, shared_high_wr} = 3'h0;
    {overflow_flag_clr, external_event_flag_clr} = 2'h0;
    {count_low_wdata, capture_low_wdata, shared_high_wdata} = 24'h000000;
    err_total = 0;
    checks_done = 0;
    r = 12'($urandom(32'hde24));
    cyc(6);
    arst_n = 1'b1;
    {pin_toggle_enable, timer_irq_enable} = 2'h3;
    load(12'hFFE, 12'h000);
    run_control = 1'b1;
    wait_for(2'h0, 12'h000);
    note(2'h2, 12'h00B);
    done(1);
    for (int i = 0; i < 4; i++)
    begin
      prescaler_select = i[1:0];
      step();
      step();
      step();
      check(n[11:0], per[i][11:0]);
    end
    r = obs(2'h0);
    count_low_wr = 1'b1;
    count_low_wdata = ~r[7:0];
    cyc(1);
    count_low_wr = 1'b0;
    note(2'h0, r);
    done(2);
    {run_control, pin_toggle_enable, mode} = {2'h0, tmc_pkg::MODE_RELOAD};
    prescaler_select = tmc_pkg::DIV_4;
    r = 12'($urandom_range(12'hFF0));
    clr_flags(2'h3);
    load(12'hFFC, r);
    run_control = 1'b1;
    wait_for(2'h2, 12'h00B);
    note(2'h0, r);
    done(3);
    {run_control, auto_reset_on_event, timer_irq_enable} = 3'h2;
    mode = tmc_pkg::MODE_CAPTURE;
    for (int s = 0; s < 2; s++)
    begin
      capture_source_select = s[0];
      clr_flags(2'h3);
      r = 12'($urandom_range(12'hFFF, 12'h001));
      load(r, 12'h000);
      if (s == 0)
        pin_u.trig_edge();
      else
        pin_u.adc_edge();
      cyc(4);
      note(2'h1, r);
      note(2'h0, 12'h000);
      note(2'h2, 12'h005);
    end
    clr_flags(2'h1);
    note(2'h2, 12'h001);
    done(4);
    {mode, pin_toggle_enable} = {tmc_pkg::MODE_COMPARE, 1'b1};
    load(12'h000, 12'h003);
    run_control = 1'b1;
    wait_for(2'h0, 12'h003);
    note(2'h2, 12'h004);
    cyc(1);
    note(2'h0, 12'h000);
    done(5);
    {run_control, mode, count_source_select} = {1'b0, 2'h0, 1'b1};
    pin_toggle_enable = 1'b0;
    load(12'h000, 12'h000);
    run_control = 1'b1;
    repeat (3) pin_u.pin_fall();
    cyc(8);
    note(2'h0, 12'h003);
    done(6);
    end_of_test();
  end
endmodule // twelve_bit_capture_compare_timer_tb_top
